//--- include/csc_pkg.sv
// Constants and types shared by the suspend control logic.
// Assumes one 125 MHz clock and a synchronous, active-low reset.
package csc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned ENTRY_MIN_CLKS  = 8;   // Request sampled to acknowledge, least
  localparam int unsigned EXIT_PIN_CLKS   = 5;   // Request released to acknowledge off
  localparam int unsigned HALT_ACK_MAX    = 40;  // Halt cycle ready to acknowledge, most
  localparam int unsigned HALT_ACK_CLKS   = 8;   // Delay used, within the maximum
  localparam int unsigned EXIT_HALT_CLKS  = 10;  // Wake interrupt to acknowledge off
  localparam int unsigned TMR_W           = 6;

  localparam logic [TMR_W-1:0] ENTRY_LOAD = TMR_W'(ENTRY_MIN_CLKS - 1);
  localparam logic [TMR_W-1:0] EXITP_LOAD = TMR_W'(EXIT_PIN_CLKS - 1);
  localparam logic [TMR_W-1:0] HALT_LOAD  = TMR_W'(HALT_ACK_CLKS - 1);
  localparam logic [TMR_W-1:0] EXITH_LOAD = TMR_W'(EXIT_HALT_CLKS - 1);

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [TMR_W-1:0] TMR_RST    = 6'h00;
  localparam logic             ACK_N_RST  = 1'b1;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    CSC_RUN   = 8'h01,  // Normal execution
    CSC_DRAIN = 8'h02,  // Finishing instructions and bus cycles
    CSC_GRANT = 8'h04,  // Stop grant bus cycle running
    CSC_ENTER = 8'h08,  // Waiting out the least entry time
    CSC_SLEEP_REQUEST_N  = 8'h10,  // Suspended by request pin
    CSC_EXITP = 8'h20,  // Leaving pin or halt suspend
    CSC_HWAIT = 8'h40,  // Halt seen, acknowledge pending
    CSC_HSUSP = 8'h80   // Suspended by halt
  } csc_state_t;

endpackage : csc_pkg

//--- logic/csc_timer.sv
// Down counter used for the suspend entry and exit delays.
// Assumes the loader pulses load for one cycle.
`timescale 1ns/100ps
`default_nettype none
module csc_timer (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     load,
  input  wire logic [csc_pkg::TMR_W-1:0] load_val,
  output var  logic                     zero
);
  import csc_pkg::*;

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
  } csc_tmr_t;

  csc_tmr_t r_q;
  csc_tmr_t r_d;

  // Load wins, otherwise count down to zero and stop
  always_comb begin
    r_d = r_q;
    if (load) begin
      r_d.cnt = load_val;
    end else if (r_q.cnt != TMR_RST) begin
      r_d.cnt = r_q.cnt - TMR_W'(1);
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      r_q.cnt <= TMR_RST;
    end else begin
      r_q <= r_d;
    end
  end

  assign zero = (r_q.cnt == TMR_RST);

endmodule : csc_timer
`default_nettype wire

//--- logic/csc_ctrl.sv
// Suspend mode sequencer: pin and halt initiated suspend, acknowledge timing,
// interrupt latching and bus release answers while suspended.
// Assumes all inputs synchronous to clk; the core reports idle and the chipset reports stop grant done.
//
// Notes on behaviour
// - On request, drain instructions and bus cycles, run stop grant, then acknowledge.
// - Request honoured only while the sleep enable bit is set.
// - Request input sampled on every rising clock edge.
// - Acknowledge comes no sooner than eight clocks after request sampled.
// - At most two more instructions run before acknowledge.
// - Acknowledge drops five clocks after request sampled inactive.
// - Request during hold acknowledge does not enter suspend until hold acknowledge clears.
// - One each of NMI, maskable and management interrupt kept during pin suspend.
// - Bus release, address release, backoff and purge still answered when suspended.
// - Halt enters suspend when the stop-on-idle bit is set.
// - Halt suspend acknowledge within 40 clocks of burst ready for halt cycle.
// - Halt suspend left on NMI, unmasked maskable or management interrupt.
// - Acknowledge drops ten clocks after the waking interrupt is sampled.
// - Clock may stop at either level while suspended; state is kept.
// - With clock stopped nothing is sampled and suspend holds.
`timescale 1ns/100ps
`default_nettype none
module csc_ctrl (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic sleep_request_n,
  input  wire logic sleep_enable_bit,
  input  wire logic stop_on_idle_bit,
  input  wire logic core_idle,
  input  wire logic instr_retire,
  input  wire logic stop_grant_done,
  input  wire logic halt_cycle,
  input  wire logic burst_ready_n,
  input  wire logic nmi_request,
  input  wire logic maskable_irq_request,
  input  wire logic irq_enable,
  input  wire logic system_mgmt_irq_n,
  input  wire logic nmi_taken,
  input  wire logic maskable_irq_request_taken,
  input  wire logic smi_taken,
  input  wire logic bus_release_request,
  input  wire logic address_release_request,
  input  wire logic bus_backoff_n,
  input  wire logic cache_purge_n,
  output var  logic sleep_ack_n,
  output var  logic core_hold_issue,
  output var  logic stop_grant_req,
  output var  logic pend_nmi,
  output var  logic pend_maskable_irq_request,
  output var  logic pend_smi,
  output var  logic hold_ack,
  output var  logic addr_release_ack,
  output var  logic backoff_ack,
  output var  logic purge_ack
);
  import csc_pkg::*;

  typedef struct packed {
    csc_state_t st;
    logic       ack_n;
    logic       hold_issue;
    logic       grant_req;
    logic [1:0] retired;
    logic       p_nmi;
    logic       p_maskable_irq_request;
    logic       p_smi;
    logic       h_ack;
    logic       a_ack;
    logic       b_ack;
    logic       f_ack;
  } csc_reg_t;

  csc_reg_t         r_q;
  csc_reg_t         r_d;
  logic             tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic             tmr_zero;
  logic             take_pin;
  logic             take_halt;
  logic             wake;
  logic             pin_sleep_request_n;

  // ----------------------------------------------------------------
  // Delay timer
  // ----------------------------------------------------------------
  csc_timer u_timer (
    .clk      (clk),
    .nrst     (nrst),
    .load     (tmr_load),
    .load_val (tmr_val),
    .zero     (tmr_zero)
  );

  // ----------------------------------------------------------------
  // Entry and wake conditions
  // ----------------------------------------------------------------
  // Request sampled each edge; held off while bus is granted away
  assign take_pin  = (r_q.st == CSC_RUN) && !sleep_request_n && sleep_enable_bit
                     && !r_q.h_ack;
  assign take_halt = (r_q.st == CSC_RUN) && halt_cycle && !burst_ready_n
                     && stop_on_idle_bit;
  assign wake      = nmi_request || (maskable_irq_request && irq_enable)
                     || !system_mgmt_irq_n;
  assign pin_sleep_request_n  = (r_q.st == CSC_DRAIN) || (r_q.st == CSC_GRANT) || (r_q.st == CSC_ENTER)
                     || (r_q.st == CSC_SLEEP_REQUEST_N) || (r_q.st == CSC_EXITP);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Sequencer; all state lives in flops so a stopped clock loses nothing
  always_comb begin
    r_d      = r_q;
    tmr_load = 1'b0;
    tmr_val  = ENTRY_LOAD;
    // Bus release requests answered in every state
    r_d.h_ack = bus_release_request;
    r_d.a_ack = address_release_request;
    r_d.b_ack = !bus_backoff_n;
    r_d.f_ack = !cache_purge_n;
    // One occurrence per interrupt kept; a new one beats the clear
    r_d.p_nmi  = (r_q.p_nmi && !nmi_taken) || (pin_sleep_request_n && nmi_request);
    r_d.p_maskable_irq_request = (r_q.p_maskable_irq_request && !maskable_irq_request_taken) || (pin_sleep_request_n && maskable_irq_request);
    r_d.p_smi  = (r_q.p_smi && !smi_taken) || (pin_sleep_request_n && !system_mgmt_irq_n);
    unique case (r_q.st)
      CSC_RUN: begin
        r_d.retired = 2'h0;
        if (take_pin) begin
          r_d.st         = CSC_DRAIN;
          r_d.hold_issue = 1'b1;
          tmr_load       = 1'b1;
          tmr_val        = ENTRY_LOAD;
        end else if (take_halt) begin
          r_d.st   = CSC_HWAIT;
          tmr_load = 1'b1;
          tmr_val  = HALT_LOAD;
        end
      end
      CSC_DRAIN: begin
        // Count retirements; a third one is never allowed to issue
        if (instr_retire && r_q.retired != 2'h2) begin
          r_d.retired = r_q.retired + 2'h1;
        end
        if (core_idle || r_q.retired == 2'h2) begin
          r_d.st        = CSC_GRANT;
          r_d.grant_req = 1'b1;
        end
      end
      CSC_GRANT: begin
        if (stop_grant_done) begin
          r_d.st        = CSC_ENTER;
          r_d.grant_req = 1'b0;
        end
      end
      CSC_ENTER: begin
        if (tmr_zero) begin
          r_d.st    = CSC_SLEEP_REQUEST_N;
          r_d.ack_n = 1'b0;
        end
      end
      CSC_SLEEP_REQUEST_N: begin
        // Request held low for the whole suspend; release starts exit
        if (sleep_request_n) begin
          r_d.st   = CSC_EXITP;
          tmr_load = 1'b1;
          tmr_val  = EXITP_LOAD;
        end
      end
      CSC_EXITP: begin
        if (tmr_zero) begin
          r_d.st         = CSC_RUN;
          r_d.ack_n      = 1'b1;
          r_d.hold_issue = 1'b0;
        end
      end
      CSC_HWAIT: begin
        if (tmr_zero) begin
          r_d.st    = CSC_HSUSP;
          r_d.ack_n = 1'b0;
        end
      end
      CSC_HSUSP: begin
        if (wake) begin
          r_d.st   = CSC_EXITP;
          tmr_load = 1'b1;
          tmr_val  = EXITH_LOAD;
        end
      end
      default: begin
        r_d.st = CSC_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset to running with acknowledge off
  always_ff @(posedge clk) begin
    if (!nrst) begin
      r_q            <= '0;
      r_q.st         <= CSC_RUN;
      r_q.ack_n      <= ACK_N_RST;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs straight from flops
  assign sleep_ack_n      = r_q.ack_n;
  assign core_hold_issue  = r_q.hold_issue;
  assign stop_grant_req   = r_q.grant_req;
  assign pend_nmi         = r_q.p_nmi;
  assign pend_maskable_irq_request        = r_q.p_maskable_irq_request;
  assign pend_smi         = r_q.p_smi;
  assign hold_ack         = r_q.h_ack;
  assign addr_release_ack = r_q.a_ack;
  assign backoff_ack      = r_q.b_ack;
  assign purge_ack        = r_q.f_ack;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  entry_min_a: assert property (@(posedge clk) disable iff (!nrst)
    take_pin |=> sleep_ack_n [*8]) else $error("Acknowledge sooner than eight clocks");

  exit_pin_a: assert property (@(posedge clk) disable iff (!nrst)
    (r_q.st == CSC_SLEEP_REQUEST_N && sleep_request_n) |=> !sleep_ack_n [*5] ##1 sleep_ack_n)
    else $error("Pin exit acknowledge not five clocks");

  exit_halt_a: assert property (@(posedge clk) disable iff (!nrst)
    (r_q.st == CSC_HSUSP && wake) |-> ##10 !sleep_ack_n ##1 sleep_ack_n)
    else $error("Halt exit acknowledge not ten clocks");

  halt_entry_a: assert property (@(posedge clk) disable iff (!nrst)
    take_halt |-> ##[1:40] !sleep_ack_n) else $error("Halt acknowledge later than 40 clocks");

  enable_gate_a: assert property (@(posedge clk) disable iff (!nrst)
    (r_q.st == CSC_RUN && !sleep_enable_bit) |=> r_q.st != CSC_DRAIN)
    else $error("Request honoured while disabled");

  ack_source_a: assert property (@(posedge clk) disable iff (!nrst)
    $fell(sleep_ack_n) |-> ($past(r_q.st) == CSC_ENTER || $past(r_q.st) == CSC_HWAIT))
    else $error("Acknowledge without grant or halt");

  pend_keep_a: assert property (@(posedge clk) disable iff (!nrst)
    (pin_sleep_request_n && nmi_request) |=> pend_nmi) else $error("Interrupt lost in suspend");

  release_ans_a: assert property (@(posedge clk) disable iff (!nrst)
    bus_release_request |=> hold_ack) else $error("Bus release not answered");

endmodule : csc_ctrl
`default_nettype wire

//--- sim/csc_partner.sv
// Chipset model: drives the sleep request pin, answers stop grant, gates the clock.
// Assumes the bench changes want_sleep and clk_run just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module csc_partner (
  input  wire logic clk_src,
  input  wire logic clk_run,
  input  wire logic want_sleep,
  input  wire logic stop_grant_req,
  output var  logic clk,
  output var  logic stop_grant_done,
  output var  logic sleep_request_n
);
  logic       run_q  = 1'b1;
  logic [1:0] cnt_q  = 2'h0;
  logic       done_q = 1'b0;

  // ----------------------------------------------------------------
  // Clock stop, enable moved while low so no runt edge appears
  // ----------------------------------------------------------------
  always @(negedge clk_src) run_q <= clk_run;
  always_comb clk = clk_src & run_q;

  // Request held low for the whole suspend, clock restarted before release
  always_comb sleep_request_n = ~want_sleep;

  // Stop grant cycle finishes three clocks after it is asked for
  always @(posedge clk) begin
    if (!stop_grant_req || cnt_q == 2'h2) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
    done_q <= stop_grant_req && cnt_q == 2'h2;
  end
  always_comb stop_grant_done = done_q;
endmodule : csc_partner
`default_nettype wire

//--- sim/csc_ctrl_tb_top.sv
// Testbench for the suspend sequencer: pin, halt and clock-stop cases.
// Assumes csc_ctrl and the chipset model csc_partner.
`timescale 1ns/100ps
`default_nettype none
module csc_ctrl_tb_top;
  import csc_pkg::*;
  logic clk_src, clk, clk_run, nrst, want_sleep, sleep_request_n, sleep_enable_bit, stop_on_idle_bit;
  logic halt_cycle, burst_ready_n, nmi_request, maskable_irq_request, irq_enable, system_mgmt_irq_n;
  logic bus_release_request, address_release_request, bus_backoff_n, cache_purge_n, stop_grant_done;
  logic sleep_ack_n, core_hold_issue, stop_grant_req, pend_nmi, pend_maskable_irq_request, pend_smi;
  logic hold_ack, addr_release_ack, backoff_ack, purge_ack;
  logic core_idle, instr_retire, nmi_taken, maskable_irq_request_taken, smi_taken;
  int   error_cnt, samples_checked, cyc;

  csc_partner i_partner (.clk_src(clk_src), .clk_run(clk_run), .want_sleep(want_sleep),
    .stop_grant_req(stop_grant_req), .clk(clk), .stop_grant_done(stop_grant_done),
    .sleep_request_n(sleep_request_n));

  csc_ctrl i_dut (.clk(clk), .nrst(nrst), .sleep_request_n(sleep_request_n),
    .sleep_enable_bit(sleep_enable_bit), .stop_on_idle_bit(stop_on_idle_bit), .core_idle(core_idle),
    .instr_retire(instr_retire), .stop_grant_done(stop_grant_done), .halt_cycle(halt_cycle),
    .burst_ready_n(burst_ready_n), .nmi_request(nmi_request), .maskable_irq_request(maskable_irq_request),
    .irq_enable(irq_enable), .system_mgmt_irq_n(system_mgmt_irq_n), .nmi_taken(nmi_taken),
    .maskable_irq_request_taken(maskable_irq_request_taken), .smi_taken(smi_taken), .bus_release_request(bus_release_request),
    .address_release_request(address_release_request), .bus_backoff_n(bus_backoff_n),
    .cache_purge_n(cache_purge_n), .sleep_ack_n(sleep_ack_n), .core_hold_issue(core_hold_issue),
    .stop_grant_req(stop_grant_req), .pend_nmi(pend_nmi), .pend_maskable_irq_request(pend_maskable_irq_request), .pend_smi(pend_smi),
    .hold_ack(hold_ack), .addr_release_ack(addr_release_ack), .backoff_ack(backoff_ack),
    .purge_ack(purge_ack));

  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk_src = 1'b0;
    forever #4 clk_src = ~clk_src;
  end

  // Hang guard, the whole run needs well under a thousand clocks
  always @(posedge clk_src) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk_src);
    #1;
  endtask : step

  // Edges from the first one after the call until the acknowledge reaches lvl
  task automatic measure(input logic lvl, output int n);
    n = 0;
    step(1);
    while (sleep_ack_n !== lvl && n < 60) begin
      n++;
      step(1);
    end
  endtask : measure

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_pin();
    int n;
    want_sleep = 1'b1;
    step(2);
    chk({7'h0, stop_grant_req}, 8'h01);
    measure(1'b0, n);
    chk(8'(n + 2 >= 8 && n < 60), 8'h01);
    chk({7'h0, core_hold_issue}, 8'h01);
    {nmi_request, maskable_irq_request, system_mgmt_irq_n} = 3'b110;
    step(1);
    {nmi_request, maskable_irq_request, system_mgmt_irq_n} = 3'b001;
    step(1);
    chk({5'h0, pend_nmi, pend_maskable_irq_request, pend_smi}, 8'h07);
    for (int i = 0; i < 16; i++) begin
      {bus_release_request, address_release_request, bus_backoff_n, cache_purge_n} = 4'(i) ^ 4'h3;
      step(1);
      chk({4'h0, hold_ack, addr_release_ack, backoff_ack, purge_ack}, 8'(i));
    end
    {bus_release_request, address_release_request, bus_backoff_n, cache_purge_n} = 4'h3;
    clk_run = 1'b0;
    step(20);
    // Inputs moved while stopped; the answers must still show the old ones
    chk({4'h0, hold_ack, addr_release_ack, backoff_ack, purge_ack}, 8'h0f);
    clk_run = 1'b1;
    step(3);
    chk({7'h0, sleep_ack_n}, 8'h00);
    want_sleep = 1'b0;
    measure(1'b1, n);
    chk(8'(n), 8'(EXIT_PIN_CLKS));
    chk({6'h0, core_hold_issue, stop_grant_req}, 8'h00);
    // Kept interrupts are serviced after suspend ends
    {nmi_taken, maskable_irq_request_taken, smi_taken} = 3'h7;
    step(1);
    {nmi_taken, maskable_irq_request_taken, smi_taken} = 3'h0;
    chk({5'h0, pend_nmi, pend_maskable_irq_request, pend_smi}, 8'h00);
    $display("pin suspend test done");
  endtask : t_pin

  // Core never idle: draining must stop after two retirements
  task automatic t_drain();
    int n;
    core_idle = 1'b0;
    want_sleep = 1'b1;
    step(1);
    instr_retire = 1'b1;
    step(2);
    instr_retire = 1'b0;
    chk({7'h0, stop_grant_req}, 8'h00);
    step(1);
    chk({7'h0, stop_grant_req}, 8'h01);
    measure(1'b0, n);
    chk(8'(n + 4 >= 8 && n < 60), 8'h01);
    want_sleep = 1'b0;
    core_idle = 1'b1;
    measure(1'b1, n);
    chk(8'(n), 8'(EXIT_PIN_CLKS));
    $display("drain limit test done");
  endtask : t_drain

  task automatic t_disabled();
    sleep_enable_bit = 1'b0;
    want_sleep = 1'b1;
    step(30);
    chk({6'h0, sleep_ack_n, core_hold_issue}, 8'h02);
    want_sleep = 1'b0;
    sleep_enable_bit = 1'b1;
    step(2);
    $display("disabled request test done");
  endtask : t_disabled

  task automatic t_halt(input logic idle_bit);
    int n;
    stop_on_idle_bit = idle_bit;
    {halt_cycle, burst_ready_n} = 2'b10;
    step(1);
    {halt_cycle, burst_ready_n} = 2'b01;
    measure(1'b0, n);
    chk(8'(n + 1), idle_bit ? 8'(HALT_ACK_CLKS) : 8'd61);
    if (idle_bit) begin
      {maskable_irq_request, irq_enable} = 2'b10;
      step(12);
      chk({7'h0, sleep_ack_n}, 8'h00);
      irq_enable = 1'b1;
      step(1);
      maskable_irq_request = 1'b0;
      measure(1'b1, n);
      chk(8'(n + 1), 8'(EXIT_HALT_CLKS));
    end
    irq_enable = 1'b0;
    $display("halt suspend test done");
  endtask : t_halt

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {clk_run, nrst, want_sleep, sleep_enable_bit, stop_on_idle_bit, halt_cycle} = 6'h24;
    {core_idle, instr_retire, nmi_taken, maskable_irq_request_taken, smi_taken} = 5'h10;
    {burst_ready_n, nmi_request, maskable_irq_request, irq_enable, system_mgmt_irq_n} = 5'h11;
    {bus_release_request, address_release_request, bus_backoff_n, cache_purge_n} = 4'h3;
    {error_cnt, samples_checked, cyc} = '0;
    step(5);
    nrst = 1'b1;
    step(1);
    chk({7'h0, sleep_ack_n}, {7'h0, ACK_N_RST});
    t_pin();
    t_drain();
    t_disabled();
    t_halt(1'b0);
    t_halt(1'b1);
    end_sim();
  end
endmodule : csc_ctrl_tb_top
`default_nettype wire
